//--- core/swss_core.sv
/*
 * swss_core: write-same fill engine, status fields and AXI4-Lite registers.
 * Assumes the media writer takes one word per valid/ready handshake and
 * that temperature samples arrive as pulses from logic on aclk.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
// Behaviour
// - report LBA of running background fill
// - current temperature, 80h when invalid
// - minimum and maximum temperature, 80h invalid
// - lifetime minimum and maximum temperature
// - count intervals above upper limit
// - count intervals below lower limit
// - action 0002h requests repeated write
// - decode background pattern and sector functions
// - decode blocking pattern and sector functions
// - pattern fill writes 32-bit value
// - accept reports 00h, 50h, length 0001h
// - write ascending from start, count sectors
// - zero count fills to last user LBA
// - never write past host protected limit
// - defect reassignment allowed during fill
// - out-of-range start or end rejected
// - full fill without error sets flag
// - other user writes clear the flag
// - read reallocations leave flag unchanged
// - background run reports status FFFFh
// - background completes when data received
// - other command aborts background, 0008h
// - blocking completes after whole fill
`timescale 1ns/1ps
module swss_core
	import swss_pkg::*;
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [swss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [swss_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       temp_sample_valid,
	input  wire logic [7:0]                 temp_sample,
	input  wire logic                       user_write,
	input  wire logic                       media_error,
	output logic                            media_wr_valid,
	input  wire logic                       media_wr_ready,
	output logic [63:0]                     media_wr_lba,
	output logic [swss_pkg::WIDX_W-1:0]     media_wr_word,
	output logic [31:0]                     media_wr_data,
	output logic                            fill_active,
	output logic                            cmd_complete
);
	import swss_pkg::*;

	swss_fill_t  state_q;
	logic [31:0] key_codes_q, pattern_q;
	logic [63:0] start_q, count_q, last_q, cur_q, end_q;
	logic [7:0]  tf_err_q, tf_stat_q, tf_cyl_lo_q, tf_cyl_hi_q;
	logic [15:0] ext_q;
	logic        bg_q, sect_q, cover_q, full_flag_q;
	logic [7:0]  t_now_q, t_min_q, t_max_q, t_lmin_q, t_lmax_q, up_lim_q, lo_lim_q;
	logic [31:0] over_q, under_q;
	logic [WIDX_W-1:0] widx_q;
	logic [31:0] sect_word;

	// register bus handshake
	logic wr_go, rd_go, wr_hit, rd_hit;
	logic [31:0] rd_val;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic wr_cmd, wr_key_issue, wr_other, wr_data_word, wr_last;
	assign wr_cmd       = wr_go && s_axi_awaddr == OFS_COMMAND && s_axi_wstrb[0];
	assign wr_key_issue = wr_cmd && s_axi_wdata[CMD_ISSUE_BIT];
	assign wr_other     = wr_cmd && s_axi_wdata[CMD_OTHER_BIT];
	assign wr_data_word = wr_go && s_axi_awaddr == OFS_SECTOR_DATA && state_q == FILL_RXDATA;
	assign wr_last      = wr_go && (s_axi_awaddr == OFS_LAST_LO || s_axi_awaddr == OFS_LAST_HI);

	always_comb begin
		wr_hit = 1'b1;
		unique case (s_axi_awaddr)
			OFS_KEY_CODES, OFS_START_LO, OFS_START_HI, OFS_COUNT_LO, OFS_COUNT_HI,
			OFS_PATTERN, OFS_COMMAND, OFS_SECTOR_DATA, OFS_LAST_LO, OFS_LAST_HI,
			OFS_LIMITS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// plain software-written registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_codes_q <= 32'h0000_0000;
			start_q     <= 64'h0000_0000_0000_0000;
			count_q     <= 64'h0000_0000_0000_0000;
			pattern_q   <= 32'h0000_0000;
			last_q      <= 64'h0000_0000_0000_0000;
			up_lim_q    <= UPPER_LIMIT_RESET;
			lo_lim_q    <= LOWER_LIMIT_RESET;
		end else if (wr_go) begin
			unique case (s_axi_awaddr)
				OFS_KEY_CODES: key_codes_q <= merge(key_codes_q, s_axi_wdata, s_axi_wstrb);
				OFS_START_LO:  start_q[31:0]  <= merge(start_q[31:0], s_axi_wdata, s_axi_wstrb);
				OFS_START_HI:  start_q[63:32] <= merge(start_q[63:32], s_axi_wdata, s_axi_wstrb);
				OFS_COUNT_LO:  count_q[31:0]  <= merge(count_q[31:0], s_axi_wdata, s_axi_wstrb);
				OFS_COUNT_HI:  count_q[63:32] <= merge(count_q[63:32], s_axi_wdata, s_axi_wstrb);
				OFS_PATTERN:   pattern_q <= merge(pattern_q, s_axi_wdata, s_axi_wstrb);
				OFS_LAST_LO:   last_q[31:0]  <= merge(last_q[31:0], s_axi_wdata, s_axi_wstrb);
				OFS_LAST_HI:   last_q[63:32] <= merge(last_q[63:32], s_axi_wdata, s_axi_wstrb);
				OFS_LIMITS: begin
					lo_lim_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : lo_lim_q;
					up_lim_q <= s_axi_wstrb[1] ? s_axi_wdata[15:8] : up_lim_q;
				end
				default: ;
			endcase
		end
	end

	// key sector decode and range check
	logic [15:0] act, func;
	logic        key_ok, range_bad, is_bg, is_sect, full_cover;
	logic [64:0] sum65, limit65;
	logic [63:0] end_lba;
	assign act     = key_codes_q[15:0];
	assign func    = key_codes_q[31:16];
	assign key_ok  = act == ACTION_WRITE_SAME && (func == FUNC_BG_PATTERN
		|| func == FUNC_BG_SECTOR || func == FUNC_BLK_PATTERN || func == FUNC_BLK_SECTOR);
	assign is_bg   = func == FUNC_BG_PATTERN || func == FUNC_BG_SECTOR;
	assign is_sect = func == FUNC_BG_SECTOR || func == FUNC_BLK_SECTOR;
	assign sum65   = {1'b0, start_q} + {1'b0, count_q};
	assign limit65 = {1'b0, last_q} + 65'd1;
	assign range_bad = start_q > last_q || (count_q != 64'h0000_0000_0000_0000
		&& sum65 > limit65);
	assign end_lba = count_q == 64'h0000_0000_0000_0000 ? last_q
		: start_q + count_q - 64'h0000_0000_0000_0001;
	assign full_cover = start_q == 64'h0000_0000_0000_0000 && end_lba == last_q;

	logic busy_bg, running, word_done, sector_done, fill_done, abort_bg;
	assign running     = state_q == FILL_FETCH || state_q == FILL_SEND;
	assign busy_bg     = bg_q && state_q != FILL_IDLE;
	assign abort_bg    = busy_bg && (wr_key_issue || wr_other);
	assign word_done   = state_q == FILL_SEND && media_wr_ready;
	assign sector_done = word_done && widx_q == WIDX_W'(SECTOR_WORDS - 1);
	assign fill_done   = sector_done && cur_q == end_q;

	// fill sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= FILL_IDLE;
			widx_q  <= '0;
			cur_q   <= 64'h0000_0000_0000_0000;
			end_q   <= 64'h0000_0000_0000_0000;
			bg_q    <= 1'b0;
			sect_q  <= 1'b0;
			cover_q <= 1'b0;
		end else if (wr_key_issue && key_ok && !range_bad) begin
			state_q <= is_sect ? FILL_RXDATA : FILL_FETCH;
			widx_q  <= '0;
			cur_q   <= start_q;
			end_q   <= end_lba;
			bg_q    <= is_bg;
			sect_q  <= is_sect;
			cover_q <= full_cover;
		end else if (wr_key_issue || abort_bg
				|| (running && media_error)) begin
			state_q <= FILL_IDLE;
		end else begin
			unique case (state_q)
				FILL_IDLE: ;
				FILL_RXDATA: if (wr_data_word) begin
					widx_q  <= widx_q + 1'b1;
					state_q <= widx_q == WIDX_W'(SECTOR_WORDS - 1) ? FILL_FETCH : FILL_RXDATA;
				end
				FILL_FETCH: state_q <= FILL_SEND;
				FILL_SEND: if (media_wr_ready) begin
					widx_q  <= widx_q + 1'b1;
					state_q <= fill_done ? FILL_IDLE : FILL_FETCH;
					if (sector_done) begin
						cur_q <= cur_q + 64'h0000_0000_0000_0001;
					end
				end
			endcase
		end
	end

	// read one word ahead so the word is ready when fetch loads it
	logic [WIDX_W-1:0] rd_idx;
	assign rd_idx = widx_q + WIDX_W'(1);

	swss_sector_mem #(
		.WIDTH(32),
		.DEPTH(SECTOR_WORDS),
		.AW   (WIDX_W)
	) u_sector (
		.aclk     (aclk),
		.wr_en    (wr_data_word),
		.wr_addr  (widx_q),
		.wr_data  (s_axi_wdata),
		.rd_addr  (rd_idx),
		.rd_data_q(sect_word)
	);

	// media word stream; reassignment of defects is the media side's business
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			media_wr_valid <= 1'b0;
			media_wr_lba   <= 64'h0000_0000_0000_0000;
			media_wr_word  <= '0;
			media_wr_data  <= 32'h0000_0000;
		end else if (state_q == FILL_FETCH && !media_error && !abort_bg) begin
			media_wr_valid <= 1'b1;
		end else if (state_q == FILL_SEND && !media_wr_ready && !media_error && !abort_bg) begin
			media_wr_valid <= 1'b1;
		end else begin
			media_wr_valid <= 1'b0;
		end
		if (aresetn && state_q == FILL_FETCH) begin
			media_wr_lba  <= cur_q;
			media_wr_word <= widx_q;
			media_wr_data <= sect_q ? sect_word : pattern_q;
		end
	end

	// task-file answer, extended status and completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tf_err_q     <= TF_ERR_NONE;
			tf_stat_q    <= TF_STAT_OK;
			tf_cyl_lo_q  <= 8'h00;
			tf_cyl_hi_q  <= 8'h00;
			ext_q        <= EXT_OK;
			cmd_complete <= 1'b0;
		end else begin
			cmd_complete <= 1'b0;
			if (abort_bg) begin
				ext_q <= EXT_ABORTED;
			end
			if (wr_key_issue) begin
				if (!key_ok || range_bad) begin
					tf_err_q     <= TF_ERR_ABORT;
					tf_stat_q    <= TF_STAT_ERR;
					ext_q        <= key_ok ? EXT_RANGE : EXT_BAD_KEY;
					cmd_complete <= 1'b1;
				end else begin
					tf_err_q     <= TF_ERR_NONE;
					tf_stat_q    <= TF_STAT_OK;
					tf_cyl_lo_q  <= TF_XFER_LO;
					tf_cyl_hi_q  <= TF_XFER_HI;
					ext_q        <= EXT_RUNNING;
					cmd_complete <= is_bg && !is_sect;
				end
			end else if (running && media_error) begin
				tf_err_q     <= TF_ERR_ABORT;
				tf_stat_q    <= TF_STAT_ERR;
				ext_q        <= bg_q ? EXT_BG_FAULT : EXT_BLK_FAULT;
				cmd_complete <= !bg_q;
			end else if (state_q == FILL_RXDATA && wr_data_word
					&& widx_q == WIDX_W'(SECTOR_WORDS - 1)) begin
				cmd_complete <= bg_q;
			end else if (fill_done) begin
				ext_q        <= EXT_OK;
				cmd_complete <= !bg_q;
			end
		end
	end

	// full-fill flag; the set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_flag_q <= 1'b0;
		end else if (fill_done && cover_q) begin
			full_flag_q <= 1'b1;
		end else if (user_write || wr_last || (state_q == FILL_FETCH && widx_q == '0)) begin
			full_flag_q <= 1'b0;
		end
	end

	// temperature history and limit counters
	logic t_valid;
	assign t_valid = temp_sample != TEMP_INVALID;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t_now_q  <= TEMP_INVALID;
			t_min_q  <= TEMP_INVALID;
			t_max_q  <= TEMP_INVALID;
			t_lmin_q <= TEMP_INVALID;
			t_lmax_q <= TEMP_INVALID;
			over_q   <= 32'h0000_0000;
			under_q  <= 32'h0000_0000;
		end else if (temp_sample_valid) begin
			t_now_q <= temp_sample;
			if (t_valid) begin
				if (t_min_q == TEMP_INVALID || $signed(temp_sample) < $signed(t_min_q))
					t_min_q <= temp_sample;
				if (t_max_q == TEMP_INVALID || $signed(temp_sample) > $signed(t_max_q))
					t_max_q <= temp_sample;
				if (t_lmin_q == TEMP_INVALID || $signed(temp_sample) < $signed(t_lmin_q))
					t_lmin_q <= temp_sample;
				if (t_lmax_q == TEMP_INVALID || $signed(temp_sample) > $signed(t_lmax_q))
					t_lmax_q <= temp_sample;
				if ($signed(temp_sample) > $signed(up_lim_q))
					over_q <= over_q + 32'h0000_0001;
				if ($signed(temp_sample) < $signed(lo_lim_q))
					under_q <= under_q + 32'h0000_0001;
			end
		end
	end

	// register read mux
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (s_axi_araddr)
			OFS_KEY_CODES:   rd_val = key_codes_q;
			OFS_START_LO:    rd_val = start_q[31:0];
			OFS_START_HI:    rd_val = start_q[63:32];
			OFS_COUNT_LO:    rd_val = count_q[31:0];
			OFS_COUNT_HI:    rd_val = count_q[63:32];
			OFS_PATTERN:     rd_val = pattern_q;
			OFS_COMMAND:     rd_val = 32'h0000_0000;
			OFS_SECTOR_DATA: rd_val = 32'h0000_0000;
			OFS_TF_MAIN:     rd_val = {tf_cyl_hi_q, tf_cyl_lo_q, tf_stat_q, tf_err_q};
			OFS_TF_EXT:      rd_val = {16'h0000, ext_q};
			OFS_LAST_LO:     rd_val = last_q[31:0];
			OFS_LAST_HI:     rd_val = last_q[63:32];
			OFS_FLAGS:       rd_val = {31'h0000_0000, full_flag_q};
			OFS_EXT_STATUS:  rd_val = {8'h00, busy_bg ? DRIVE_SCT_BG : DRIVE_ACTIVE, ext_q};
			OFS_CUR_LO:      rd_val = cur_q[31:0];
			OFS_CUR_HI:      rd_val = cur_q[63:32];
			OFS_TEMPS:       rd_val = {t_lmin_q, t_max_q, t_min_q, t_now_q};
			OFS_TEMP_LIFE:   rd_val = {24'h00_0000, t_lmax_q};
			OFS_OVER_COUNT:  rd_val = over_q;
			OFS_UNDER_COUNT: rd_val = under_q;
			OFS_LIMITS:      rd_val = {16'h0000, up_lim_q, lo_lim_q};
			default:         rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fill_active <= 1'b0;
		end else begin
			fill_active <= state_q != FILL_IDLE;
		end
	end
endmodule // swss_core

//--- core/swss_pkg.sv
/*
 * swss_pkg: constants shared by the write-same / status core.
 * Assumes an AXI4-Lite master with 32-bit data and a media writer taking words.
 */
package swss_pkg;
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned SECTOR_WORDS = 128;
	localparam int unsigned WIDX_W       = 7;

	// register byte offsets
	localparam logic [7:0] OFS_KEY_CODES   = 8'h00; // [15:0] action, [31:16] function
	localparam logic [7:0] OFS_START_LO    = 8'h04;
	localparam logic [7:0] OFS_START_HI    = 8'h08;
	localparam logic [7:0] OFS_COUNT_LO    = 8'h0C;
	localparam logic [7:0] OFS_COUNT_HI    = 8'h10;
	localparam logic [7:0] OFS_PATTERN     = 8'h14;
	localparam logic [7:0] OFS_COMMAND     = 8'h18; // bit0 issue key sector, bit1 other cmd
	localparam logic [7:0] OFS_SECTOR_DATA = 8'h1C;
	localparam logic [7:0] OFS_TF_MAIN     = 8'h20; // err, status, cyl lo, cyl hi
	localparam logic [7:0] OFS_TF_EXT      = 8'h24; // sector count, sector number
	localparam logic [7:0] OFS_LAST_LO     = 8'h28;
	localparam logic [7:0] OFS_LAST_HI     = 8'h2C;
	localparam logic [7:0] OFS_FLAGS       = 8'h30;
	localparam logic [7:0] OFS_EXT_STATUS  = 8'h34; // [15:0] ext, [23:16] drive status
	localparam logic [7:0] OFS_CUR_LO      = 8'h38;
	localparam logic [7:0] OFS_CUR_HI      = 8'h3C;
	localparam logic [7:0] OFS_TEMPS       = 8'h40; // now, min, max, life min
	localparam logic [7:0] OFS_TEMP_LIFE   = 8'h44; // [7:0] life max
	localparam logic [7:0] OFS_OVER_COUNT  = 8'h48;
	localparam logic [7:0] OFS_UNDER_COUNT = 8'h4C;
	localparam logic [7:0] OFS_LIMITS      = 8'h50; // [7:0] lower, [15:8] upper

	localparam int unsigned CMD_ISSUE_BIT = 0;
	localparam int unsigned CMD_OTHER_BIT = 1;
	localparam int unsigned FLAG_FULL_BIT = 0;

	localparam logic [15:0] ACTION_WRITE_SAME = 16'h0002;
	localparam logic [15:0] FUNC_BG_PATTERN   = 16'h0001;
	localparam logic [15:0] FUNC_BG_SECTOR    = 16'h0002;
	localparam logic [15:0] FUNC_BLK_PATTERN  = 16'h0101;
	localparam logic [15:0] FUNC_BLK_SECTOR   = 16'h0102;

	localparam logic [15:0] EXT_OK          = 16'h0000;
	localparam logic [15:0] EXT_BAD_KEY     = 16'h0001;
	localparam logic [15:0] EXT_RANGE       = 16'h0002;
	localparam logic [15:0] EXT_ABORTED     = 16'h0008;
	localparam logic [15:0] EXT_BG_FAULT    = 16'h0009;
	localparam logic [15:0] EXT_BLK_FAULT   = 16'h0017;
	localparam logic [15:0] EXT_RUNNING     = 16'hFFFF;

	localparam logic [7:0] TF_ERR_NONE   = 8'h00;
	localparam logic [7:0] TF_ERR_ABORT  = 8'h04;
	localparam logic [7:0] TF_STAT_OK    = 8'h50;
	localparam logic [7:0] TF_STAT_ERR   = 8'h51;
	localparam logic [7:0] TF_XFER_LO    = 8'h01;
	localparam logic [7:0] TF_XFER_HI    = 8'h00;

	localparam logic [7:0] DRIVE_ACTIVE  = 8'h00;
	localparam logic [7:0] DRIVE_SCT_BG  = 8'h05;
	localparam logic [7:0] TEMP_INVALID  = 8'h80;
	localparam logic [7:0] UPPER_LIMIT_RESET = 8'h00;
	localparam logic [7:0] LOWER_LIMIT_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		FILL_IDLE   = 2'b00,
		FILL_RXDATA = 2'b01,
		FILL_FETCH  = 2'b10,
		FILL_SEND   = 2'b11
	} swss_fill_t;
endpackage

//--- core/swss_sector_mem.sv
/*
 * swss_sector_mem: holds the host-supplied fill sector.
 * Assumes one writer and one reader on the same clock; read data registered.
 */
`timescale 1ns/1ps
module swss_sector_mem #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 128,
	parameter int unsigned AW    = 7
) (
	input  wire logic             aclk,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule // swss_sector_mem

//--- tb/swss_assertions.sv
/* swss_assertions: port-level checks on swss_core.
 * Assumes a bind onto swss_core; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module swss_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        media_wr_valid,
	input wire logic        media_wr_ready,
	input wire logic [63:0] media_wr_lba,
	input wire logic [6:0]  media_wr_word,
	input wire logic [31:0] media_wr_data,
	input wire logic        fill_active,
	input wire logic        cmd_complete
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_MEDIA_HOLD: assert property (media_wr_valid && !media_wr_ready |=> (media_wr_valid
		&& $stable(media_wr_lba) && $stable(media_wr_word) && $stable(media_wr_data))
		or (!media_wr_valid ##1 !fill_active)) else $error("stalled media word changed");
	AST_MEDIA_NEXT: assert property (media_wr_valid && media_wr_ready && media_wr_word != 7'd127
		|=> !media_wr_valid ##1 (!media_wr_valid || (media_wr_lba == $past(media_wr_lba, 2)
		&& media_wr_word == $past(media_wr_word, 2) + 7'd1))) else $error("word order broken");
	AST_MEDIA_WRAP: assert property (media_wr_valid && media_wr_ready && media_wr_word == 7'd127
		|=> !media_wr_valid ##1 (!media_wr_valid || (media_wr_word == 7'd0
		&& media_wr_lba == $past(media_wr_lba, 2) + 64'd1))) else $error("sector order broken");
	AST_DONE_PULSE: assert property (cmd_complete |=> !cmd_complete)
		else $error("completion longer than one cycle");
	AST_IDLE_QUIET: assert property (media_wr_valid |-> fill_active)
		else $error("media write while idle");
	AST_WR_RESP: assert property (s_axi_awready |-> s_axi_wready && s_axi_bvalid ##1 !s_axi_awready)
		else $error("write accept malformed");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_AR_PULSE: assert property (s_axi_arready |-> s_axi_rvalid ##1 !s_axi_arready)
		else $error("read accept malformed");
endmodule // swss_assertions

bind swss_core swss_assertions u_swss_chk (.*);

//--- tb/swss_media_model.sv
/* swss_media_model: media writer on the fill stream, checks each word.
 * Assumes one word per valid/ready handshake; slow stalls three cycles in four. */
`timescale 1ns/1ps
module swss_media_model (
	input wire logic        aclk,
	input wire logic        clr,
	input wire logic        slow,
	input wire logic        sector_mode,
	input wire logic [31:0] pattern,
	input wire logic        media_wr_valid,
	input wire logic [63:0] media_wr_lba,
	input wire logic [6:0]  media_wr_word,
	input wire logic [31:0] media_wr_data,
	output logic            media_wr_ready,
	output int              n_acc,
	output int              n_bad,
	output logic [63:0]     lo_lba,
	output logic [63:0]     hi_lba
);
	logic [1:0] stall_q = 2'b00;
	assign media_wr_ready = !slow || (stall_q == 2'b11);
	always_ff @(posedge aclk) begin
		stall_q <= stall_q + 2'b01;
		if (clr) begin
			n_acc <= 0;
			n_bad <= 0;
		end else if (media_wr_valid && media_wr_ready) begin
			n_acc <= n_acc + 1;
			if (n_acc == 0)
				lo_lba <= media_wr_lba;
			hi_lba <= media_wr_lba;
			if (media_wr_data !== (sector_mode ? {25'h0, media_wr_word} : pattern))
				n_bad <= n_bad + 1;
		end
	end
endmodule // swss_media_model

//--- tb/tb_top.sv
/* tb_top: self-checking bench for swss_core with a media writer model.
 * Assumes the register map and handshake timing of the hand-over. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
	import swss_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} swss_row_t;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, temp_sample_valid, user_write, media_error, media_wr_valid;
	logic        media_wr_ready, fill_active, cmd_complete, clr, slow, sector_mode;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, temp_sample;
	logic [31:0] s_axi_wdata, s_axi_rdata, media_wr_data, pattern, rd_v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp_v;
	logic [63:0] media_wr_lba, lo_lba, hi_lba;
	logic [6:0]  media_wr_word;
	int          err_total, n_compared, n_done, n_acc, n_bad, base;
	logic [15:0] funcs [2] = '{FUNC_BLK_SECTOR, FUNC_BG_SECTOR};
	logic [7:0]  temps [4] = '{8'h80, 8'h19, 8'hFB, 8'h28};
	swss_row_t   rows [9] = '{'{8'h20, 32'h0000_5000, 2'b00}, '{8'h24, 32'h0, 2'b00},
		'{8'h30, 32'h0, 2'b00}, '{8'h34, 32'h0, 2'b00}, '{8'h40, 32'h8080_8080, 2'b00},
		'{8'h44, 32'h0000_0080, 2'b00}, '{8'h48, 32'h0, 2'b00}, '{8'h4C, 32'h0, 2'b00},
		'{8'h60, 32'h0, RESP_SLVERR}};

	swss_core DUT (.*);
	swss_media_model u_media (.*);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) if (cmd_complete === 1'b1) n_done++;

	task end_sim;
		if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		resp_v = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		rd_v = s_axi_rdata;
		resp_v = s_axi_rresp;
	endtask
	task issue(input logic [15:0] f, input logic [31:0] st, input logic [31:0] cnt);
		@(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		base = n_done;
		wr(8'h00, {f, ACTION_WRITE_SAME});
		wr(8'h04, st);
		wr(8'h0C, cnt);
		wr(8'h14, pattern);
		wr(8'h18, 32'h0000_0001);
	endtask
	task done_wait;
		while (n_done <= base) @(posedge aclk);
	endtask

	initial begin
		#400_000;
		err_total++;
		end_sim;
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
			temp_sample_valid, user_write, media_error, slow, sector_mode, s_axi_awaddr,
			s_axi_araddr, temp_sample, s_axi_wdata, pattern} = '0;
		s_axi_wstrb = 4'hF;
		clr = 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a);
			`CHK("reset register", {rows[i].r, rows[i].d}, {resp_v, rd_v})
		end
		wr(8'h60, 32'h0000_0001);
		`CHK("unmapped write", RESP_SLVERR, resp_v)
		wr(8'h28, 32'h0000_0003);
		wr(8'h2C, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h10, 32'h0);
		wr(8'h50, 32'h0000_1E00);
		issue(FUNC_BLK_PATTERN, 32'h2, 32'h3);
		done_wait;
		rd(8'h20);
		`CHK("range taskfile", 16'h5104, rd_v[15:0])
		rd(8'h24);
		`CHK("range ext", EXT_RANGE, rd_v[15:0])
		`CHK("range writes", 0, n_acc)
		wr(8'h00, 32'h0001_0003);
		wr(8'h18, 32'h0000_0001);
		rd(8'h24);
		`CHK("bad key ext", EXT_BAD_KEY, rd_v[15:0])
		slow <= 1'b1;
		pattern <= 32'hA5A5_0F0F;
		issue(FUNC_BLK_PATTERN, 32'h0, 32'h0);
		rd(8'h20);
		`CHK("accept taskfile", 32'h0001_5000, rd_v)
		done_wait;
		`CHK("full words", 512, n_acc)
		`CHK("full first", 64'h0, lo_lba)
		`CHK("full last", 64'h3, hi_lba)
		`CHK("pattern data", 0, n_bad)
		rd(8'h30);
		`CHK("full flag", 32'h1, rd_v)
		@(posedge aclk);
		user_write <= 1'b1;
		@(posedge aclk);
		user_write <= 1'b0;
		rd(8'h30);
		`CHK("flag cleared", 32'h0, rd_v)
		issue(FUNC_BG_PATTERN, 32'h1, 32'h2);
		done_wait;
		`CHK("bg early done", 1'b1, n_acc < 256)
		rd(8'h34);
		`CHK("bg status", 32'h0005_FFFF, rd_v)
		rd(8'h38);
		`CHK("bg lba", 1'b1, rd_v >= 32'h1 && rd_v <= 32'h2)
		wr(8'h18, 32'h0000_0002);
		rd(8'h34);
		`CHK("abort status", EXT_ABORTED, rd_v[15:0])
		issue(FUNC_BLK_PATTERN, 32'h0, 32'h1);
		@(posedge aclk);
		media_error <= 1'b1;
		@(posedge aclk);
		media_error <= 1'b0;
		done_wait;
		rd(8'h24);
		`CHK("fault ext", EXT_BLK_FAULT, rd_v[15:0])
		rd(8'h20);
		`CHK("fault taskfile", 16'h5104, rd_v[15:0])
		sector_mode <= 1'b1;
		foreach (funcs[j]) begin
			issue(funcs[j], 32'h3, 32'h1);
			for (int i = 0; i < 128; i++)
				wr(8'h1C, i);
			done_wait;
			while (fill_active !== 1'b0) @(posedge aclk);
			`CHK("sector words", 128, n_acc)
			`CHK("sector data", 0, n_bad)
		end
		foreach (temps[i]) begin
			@(posedge aclk);
			temp_sample_valid <= 1'b1;
			temp_sample <= temps[i];
		end
		@(posedge aclk);
		temp_sample_valid <= 1'b0;
		rd(8'h40);
		`CHK("temperatures", 32'hFB28_FB28, rd_v)
		rd(8'h44);
		`CHK("life max", 8'h28, rd_v[7:0])
		rd(8'h48);
		`CHK("over count", 32'h1, rd_v)
		rd(8'h4C);
		`CHK("under count", 32'h1, rd_v)
		end_sim;
	end
endmodule // tb_top
